/* standby_consts.vh */
// Constants of the standby mode controller
// Summary of operation
// - Halt instruction gates the CPU clock; main oscillator keeps running.
// - Stop instruction stops the main oscillator and everything clocked from it.
// - Registers, memory, port latches and buffers are held in both standby modes.
// - Stop only from main clock; halt from main or subsystem clock.
// - An interrupt request may release stop mode.
// - After interrupt release of stop, wait the selected settle time first.
// - Settle select register resets to 04h, the longest wait of 2^17.
// - Reset release of stop always waits 2^17 main clock periods.
// - Codes 000,001,010,111,100 give 2^12,2^14,2^15,2^16,2^17; others prohibited.
// - Wait counting starts only once the oscillator has restarted.
// - Halt stops CPU, converter and CAN; latches held; external interrupts live.
// - Peripheral enables in halt depend on whether main or subsystem clock ran.
// - Halt bus: data lines high impedance, upper address held, strobes parked.
// - Unmasked request releases halt; vectored if acknowledge enabled, else next.
// - Halt wake latency is 8 to 9 clocks vectored, 2 to 3 otherwise.
// - Non-maskable request releases halt and always takes vectored service.
// - Reset during halt releases the mode and runs normal reset processing.
// - Pending unmasked request at stop falls to halt, resumes after settle wait.
`ifndef STANDBY_CONSTS_VH
`define STANDBY_CONSTS_VH
`define SETTLE_SEL_ADDR   16'hfffa
`define SETTLE_SEL_RESET  3'h4
`define SEL_2P12          3'h0
`define SEL_2P14          3'h1
`define SEL_2P15          3'h2
`define SEL_2P16          3'h7
`define SEL_2P17          3'h4
`define WAIT_2P12         18'h01000
`define WAIT_2P14         18'h04000
`define WAIT_2P15         18'h08000
`define WAIT_2P16         18'h10000
`define WAIT_2P17         18'h20000
`define WAKE_VECTORED     4'h8
`define WAKE_SEQUENTIAL   4'h2
`endif

/* settle_counter.v */
// Oscillation settle wait down counter
`timescale 1ns/1ps
`include "standby_consts.vh"
module settle_counter #(
   parameter WIDTH = 18
) (
   input  wire             core_clk,
   input  wire             reset,
   input  wire             load,
   input  wire [WIDTH-1:0] loadValue,
   input  wire             countEnable,
   output wire             done
);
   reg [WIDTH-1:0] count_reg;
   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   // Load then count down
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         count_reg <= {WIDTH{1'b0}};
      end else if (load) begin
         count_reg <= loadValue;
      end else if (countEnable && (count_reg != {WIDTH{1'b0}})) begin
         count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
   assign done = (count_reg == {WIDTH{1'b0}}) && !load;
endmodule // settle_counter

/* standby_mode_controller.v */
// Standby mode controller: halt, stop, settle wait and bus parking
`timescale 1ns/1ps
`include "standby_consts.vh"
module standby_mode_controller #(
   parameter WIDTH = 18
) (
   input  wire        core_clk,
   input  wire        reset,
   input  wire        haltInstr,
   input  wire        stopInstr,
   input  wire        onSubClock,
   input  wire        intPending,
   input  wire        intMasked,
   input  wire        intAckEnable,
   input  wire        nmiRequest,
   input  wire        oscRunning,
   input  wire        extIntPins,
   input  wire [15:0] regAddr,
   input  wire [7:0]  regWdata,
   input  wire        regWrite,
   input  wire        regRead,
   input  wire [7:0]  busAddrHigh,
   output reg  [7:0]  regRdata,
   output reg         cpuClockEnable,
   output reg         mainOscEnable,
   output reg         cpuResume,
   output reg         vectoredService,
   output reg         adcEnable,
   output reg         canEnable,
   output reg         timer16Enable,
   output reg         watchdogEnable,
   output reg         soundEnable,
   output reg         displayEnable,
   output reg         timer8ExtOnly,
   output reg         portLatchHold,
   output reg         muxedAddrDataOe,
   output reg  [7:0]  upperAddressLines,
   output reg         busAddressStrobe,
   output reg         busReadStrobeN,
   output reg         busWriteStrobeN,
   output reg         extIntLive
);
   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam RUN    = 5'b00001;
   localparam HALT   = 5'b00010;
   localparam STOP   = 5'b00100;
   localparam SETTLE = 5'b01000;
   localparam WAKE   = 5'b10000;

   reg  [4:0]       state_reg;
   reg  [4:0]       state_next;
   reg  [2:0]       settle_time_select_reg;
   reg              subHalt_reg;
   reg              vector_reg;
   reg              vector_next;
   reg  [3:0]       wake_reg;
   reg  [3:0]       wake_next;
   reg              fromReset_reg;
   reg              oscMeta_reg;
   reg              oscSync_reg;
   reg              extMeta_reg;
   reg              extSync_reg;
   reg              load;
   reg  [WIDTH-1:0] loadValue;
   wire             settleDone;
   wire             unmasked;
   wire             wakeEvent;

   wire settle_sel_bit2 = settle_time_select_reg[2];
   wire settle_sel_bit1 = settle_time_select_reg[1];
   wire settle_sel_bit0 = settle_time_select_reg[0];

   assign unmasked  = intPending && !intMasked;
   assign wakeEvent = unmasked || nmiRequest;

   // ---------------------------------------------------------------
   // Synchronisers
   // ---------------------------------------------------------------
   // Oscillator status comes from the analog side, outside this clock
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         oscMeta_reg <= 1'b0;
         oscSync_reg <= 1'b0;
      end else begin
         oscMeta_reg <= oscRunning;
         oscSync_reg <= oscMeta_reg;
      end
   end

   // Interrupt pins are asynchronous; only the second flop is read
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         extMeta_reg <= 1'b0;
         extSync_reg <= 1'b0;
      end else begin
         extMeta_reg <= extIntPins;
         extSync_reg <= extMeta_reg;
      end
   end

   // ---------------------------------------------------------------
   // Settle time select register
   // ---------------------------------------------------------------
   // Reset to longest wait
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         settle_time_select_reg <= `SETTLE_SEL_RESET;
      end else if (regWrite && (regAddr == `SETTLE_SEL_ADDR)) begin
         settle_time_select_reg <= regWdata[2:0];
      end
   end

   // Upper bits read as zero
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         regRdata <= 8'h00;
      end else if (regRead && (regAddr == `SETTLE_SEL_ADDR)) begin
         regRdata <= {5'h00, settle_sel_bit2, settle_sel_bit1, settle_sel_bit0};
      end else begin
         regRdata <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Settle wait selection
   // ---------------------------------------------------------------
   // Code to wait length
   always @* begin
      case (settle_time_select_reg)
         `SEL_2P12: loadValue = `WAIT_2P12;
         `SEL_2P14: loadValue = `WAIT_2P14;
         `SEL_2P15: loadValue = `WAIT_2P15;
         `SEL_2P16: loadValue = `WAIT_2P16;
         // Prohibited codes fall back to the longest, safest wait
         default:   loadValue = `WAIT_2P17;
      endcase
      if (fromReset_reg) begin
         loadValue = `WAIT_2P17;
      end
   end

   settle_counter #(
      .WIDTH (WIDTH)
   ) u_settle (
      .core_clk    (core_clk),
      .reset       (reset),
      .load        (load),
      .loadValue   (loadValue),
      .countEnable (oscSync_reg),
      .done        (settleDone)
   );

   // ---------------------------------------------------------------
   // Mode sequencer
   // ---------------------------------------------------------------
   always @* begin
      state_next  = state_reg;
      vector_next = vector_reg;
      wake_next   = wake_reg;
      // Reset wait loads on the first edge
      load        = fromReset_reg;
      case (state_reg)
         RUN: begin
            if (stopInstr && !onSubClock && wakeEvent) begin
               state_next  = SETTLE;
               load        = 1'b1;
               vector_next = nmiRequest || intAckEnable;
            end else if (stopInstr && !onSubClock) begin
               state_next = STOP;
            end else if (haltInstr) begin
               state_next = HALT;
            end
         end
         HALT: begin
            if (nmiRequest) begin
               state_next  = WAKE;
               vector_next = 1'b1;
               wake_next   = `WAKE_VECTORED;
            end else if (unmasked) begin
               state_next  = WAKE;
               vector_next = intAckEnable;
               wake_next   = intAckEnable ? `WAKE_VECTORED : `WAKE_SEQUENTIAL;
            end
         end
         STOP: begin
            if (wakeEvent) begin
               state_next  = SETTLE;
               load        = 1'b1;
               vector_next = nmiRequest || intAckEnable;
            end
         end
         SETTLE: begin
            if (settleDone) begin
               state_next = WAKE;
               wake_next  = `WAKE_SEQUENTIAL;
            end
         end
         WAKE: begin
            if (wake_reg == 4'h1) begin
               state_next = RUN;
            end else begin
               wake_next = wake_reg - 4'h1;
            end
         end
         default: state_next = RUN;
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Reset releases any mode
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_reg  <= SETTLE;
         vector_reg <= 1'b0;
         wake_reg   <= 4'h0;
      end else begin
         state_reg  <= state_next;
         vector_reg <= vector_next;
         wake_reg   <= wake_next;
      end
   end

   // ---------------------------------------------------------------
   // Clock source and reset wait flag
   // ---------------------------------------------------------------
   // Sampled only while running, so it holds through standby
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         subHalt_reg <= 1'b0;
      end else if (state_reg == RUN) begin
         subHalt_reg <= onSubClock;
      end
   end

   // Reset wait loaded once, on the first edge
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         fromReset_reg <= 1'b1;
      end else begin
         fromReset_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Wake cycles still count as halted for the peripherals
   wire inRun     = (state_reg == RUN);
   wire inHalt    = (state_reg == HALT) || (state_reg == WAKE);
   wire inStop    = (state_reg == STOP) || (state_reg == SETTLE);
   // Sub clock halt stops the main-clock peripherals
   wire mainHalt  = inHalt && !subHalt_reg;
   // Next state, so CPU clock, units and data lines drop together
   wire runNext   = (state_next == RUN);
   // Reset-time load also goes through the counter
   wire resetLoad = fromReset_reg;

   // ---------------------------------------------------------------
   // Clock gating and wake pulses
   // ---------------------------------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cpuClockEnable  <= 1'b0;
         mainOscEnable   <= 1'b1;
         cpuResume       <= 1'b0;
         vectoredService <= 1'b0;
      end else begin
         cpuClockEnable  <= runNext;
         mainOscEnable   <= !(state_next == STOP) || resetLoad;
         // One-cycle pulses in the first run cycle after the last wake cycle
         cpuResume       <= (state_reg == WAKE) && runNext;
         vectoredService <= (state_reg == WAKE) && runNext && vector_reg;
      end
   end

   // ---------------------------------------------------------------
   // Peripheral enables
   // ---------------------------------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         adcEnable      <= 1'b0;
         canEnable      <= 1'b0;
         timer16Enable  <= 1'b0;
         watchdogEnable <= 1'b0;
         soundEnable    <= 1'b0;
         displayEnable  <= 1'b0;
         timer8ExtOnly  <= 1'b0;
         extIntLive     <= 1'b0;
      end else begin
         adcEnable      <= runNext;
         canEnable      <= runNext;
         timer16Enable  <= inRun || mainHalt;
         watchdogEnable <= inRun || mainHalt;
         soundEnable    <= inRun || mainHalt;
         displayEnable  <= inRun || mainHalt;
         // 8-bit timers on external or sub clock only
         timer8ExtOnly  <= inStop || (inHalt && subHalt_reg);
         // External interrupts live in every mode
         extIntLive     <= extSync_reg;
      end
   end

   // ---------------------------------------------------------------
   // Port latches and expansion bus parking
   // ---------------------------------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         portLatchHold     <= 1'b1;
         muxedAddrDataOe   <= 1'b0;
         upperAddressLines <= 8'h00;
         busAddressStrobe  <= 1'b0;
         busReadStrobeN    <= 1'b1;
         busWriteStrobeN   <= 1'b1;
      end else begin
         portLatchHold   <= !runNext;
         muxedAddrDataOe <= runNext;
         // Upper address keeps its last running value
         if (inRun) begin
            upperAddressLines <= busAddrHigh;
         end
         // Strobes idle; the bus unit owns them while running
         busAddressStrobe <= 1'b0;
         busReadStrobeN   <= 1'b1;
         busWriteStrobeN  <= 1'b1;
      end
   end
endmodule // standby_mode_controller

/* standby_mode_controller_chk.sv */
// Assertion checker for the standby mode controller
`timescale 1ns/1ps
module standby_mode_controller_chk (
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic       haltInstr,
   input wire logic       stopInstr,
   input wire logic       onSubClock,
   input wire logic       cpuClockEnable,
   input wire logic       mainOscEnable,
   input wire logic       adcEnable,
   input wire logic       canEnable,
   input wire logic       portLatchHold,
   input wire logic       muxedAddrDataOe,
   input wire logic [7:0] upperAddressLines,
   input wire logic       busAddressStrobe,
   input wire logic       busReadStrobeN,
   input wire logic       busWriteStrobeN,
   input wire logic       cpuResume,
   input wire logic       vectoredService
);
   // One clock domain, so one default for all
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (reset);
   park_a: assert property (
      !busAddressStrobe && busReadStrobeN && busWriteStrobeN) else $error("strobes not parked");
   data_hiz_a: assert property (
      !cpuClockEnable |-> !muxedAddrDataOe) else $error("data lines driven in standby");
   halt_gate_a: assert property (
      haltInstr && cpuClockEnable |=> !cpuClockEnable && mainOscEnable) else $error("halt entry");
   halt_units_a: assert property (
      haltInstr && cpuClockEnable |=> !adcEnable && !canEnable) else $error("units run in halt");
   stop_sub_a: assert property (
      stopInstr && !haltInstr && onSubClock && cpuClockEnable |=> cpuClockEnable && mainOscEnable)
      else $error("stop taken on sub clock");
   latch_hold_a: assert property (
      !cpuClockEnable |-> portLatchHold) else $error("port latches released");
   upper_hold_a: assert property (
      !cpuClockEnable && !$past(cpuClockEnable) |-> $stable(upperAddressLines))
      else $error("upper address moved");
   vector_pair_a: assert property (
      vectoredService |-> cpuResume) else $error("vector without resume");
endmodule // standby_mode_controller_chk

bind standby_mode_controller standby_mode_controller_chk standby_mode_controller_chk_i (.*);

/* osc_int_model.sv */
// Oscillator and interrupt controller model facing the controller
`timescale 1ns/1ps
module osc_int_model #(
   parameter int START = 40
) (
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic mainOscEnable,
   input  wire logic cpuResume,
   input  wire logic irqPulse,
   output logic      oscRunning,
   output logic      intPending
);
   int startCnt;
   always @(posedge core_clk or posedge reset) begin
      if (reset || !mainOscEnable) begin
         startCnt <= 0;
         oscRunning <= 1'b0;
      end else if (startCnt < START) begin
         startCnt <= startCnt + 1;
      end else begin
         oscRunning <= 1'b1;
      end
   end
   always @(posedge core_clk or posedge reset) begin
      if (reset)
         intPending <= 1'b0;
      else if (irqPulse)
         intPending <= 1'b1;
      else if (cpuResume)
         intPending <= 1'b0;
   end
endmodule // osc_int_model

/* standby_mode_controller_tb_top.sv */
// Self-checking testbench for the standby mode controller
`timescale 1ns/1ps
module standby_mode_controller_tb_top;
   logic        core_clk, reset, haltInstr, stopInstr, onSubClock, intPending, intMasked;
   logic        intAckEnable, nmiRequest, oscRunning, extIntPins, regWrite, regRead, irqPulse;
   logic [15:0] regAddr;
   logic [7:0]  regWdata, busAddrHigh, regRdata, upperAddressLines;
   logic        cpuClockEnable, mainOscEnable, cpuResume, vectoredService, adcEnable, canEnable;
   logic        timer16Enable, watchdogEnable, soundEnable, displayEnable, timer8ExtOnly;
   logic        portLatchHold, muxedAddrDataOe, busAddressStrobe, busReadStrobeN;
   logic        busWriteStrobeN, extIntLive, vec;
   int          num_errors = 0, n_tests = 0, n;

   standby_mode_controller #(.WIDTH(18)) standby_mode_controller_i (.*);
   osc_int_model #(.START(40)) osc_int_model_i (.core_clk(core_clk), .reset(reset),
      .mainOscEnable(mainOscEnable), .cpuResume(cpuResume), .irqPulse(irqPulse),
      .oscRunning(oscRunning), .intPending(intPending));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic chkRange(input string what, input int lo, hi, got);
      n_tests++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input string what);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      @(posedge core_clk);
      chk(what, e, regRdata);
   endtask
   // Counts running-oscillator cycles up to resume or clock enable
   task automatic waitRes(input int bound, input bit onClk);
      n = 0;
      for (int i = 0; i < bound; i++) begin
         @(posedge core_clk);
         if ((onClk ? cpuClockEnable : cpuResume) === 1'b1) begin
            vec = vectoredService;
            return;
         end
         if (oscRunning === 1'b1)
            n++;
      end
      num_errors++;
      $display("[FAIL] wake expected resume seen none");
      wrap_up();
   endtask
   task automatic t_halt(input logic ack, nmi, sub, input int lo, hi);
      onSubClock <= sub;
      intAckEnable <= ack;
      busAddrHigh <= 8'h5a;
      extIntPins <= 1'b1;
      @(posedge core_clk);
      haltInstr <= 1'b1;
      @(posedge core_clk);
      haltInstr <= 1'b0;
      busAddrHigh <= 8'ha5;
      irqPulse <= 1'b1;
      intMasked <= 1'b1;
      @(posedge core_clk);
      irqPulse <= 1'b0;
      repeat (12) begin
         @(posedge core_clk);
         chk("resume while masked", 1'b0, cpuResume);
      end
      chk("halt state", 14'h15a3, {cpuClockEnable, mainOscEnable, upperAddressLines, adcEnable,
         canEnable, extIntLive, portLatchHold});
      chk("halt units", {{4{~sub}}, sub}, {timer16Enable, watchdogEnable, soundEnable,
         displayEnable, timer8ExtOnly});
      if (nmi)
         nmiRequest <= 1'b1;
      else
         intMasked <= 1'b0;
      waitRes(40, 1'b0);
      chkRange("halt wake latency", lo, hi, n);
      chk("vectored service", ack | nmi, vec);
      nmiRequest <= 1'b0;
      intMasked <= 1'b0;
      onSubClock <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic t_stop(input logic pend);
      wr(16'hfffa, 8'h00);
      onSubClock <= 1'b1;
      stopInstr <= 1'b1;
      @(posedge core_clk);
      stopInstr <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("stop on sub clock", 2'b11, {cpuClockEnable, mainOscEnable});
      onSubClock <= 1'b0;
      intAckEnable <= 1'b1;
      irqPulse <= pend;
      @(posedge core_clk);
      irqPulse <= 1'b0;
      stopInstr <= 1'b1;
      @(posedge core_clk);
      stopInstr <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("oscillator in stop", {pend, 1'b0}, {mainOscEnable, cpuClockEnable});
      irqPulse <= ~pend;
      @(posedge core_clk);
      irqPulse <= 1'b0;
      waitRes(6000, 1'b0);
      chkRange("stop settle cycles", 4090, 4104, n);
      chk("vectored after stop", 1'b1, vec);
   endtask

   initial begin
      {reset, haltInstr, stopInstr, onSubClock, intMasked, intAckEnable} = 6'h20;
      {nmiRequest, extIntPins, regWrite, regRead, irqPulse} = 5'h00;
      regAddr = 16'h0000;
      regWdata = 8'h00;
      busAddrHigh = 8'h00;
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      rd(16'hfffa, 8'h04, "select after reset");
      waitRes(140000, 1'b1);
      chkRange("reset settle cycles", 131072, 131084, n);
      wr(16'hfffa, 8'hff);
      rd(16'hfffa, 8'h07, "select low bits");
      wr(16'hfff8, 8'h00);
      rd(16'hfffa, 8'h07, "select after unmapped write");
      rd(16'hfff8, 8'h00, "unmapped read");
      t_halt(1'b1, 1'b0, 1'b0, 8, 10);
      t_halt(1'b0, 1'b0, 1'b1, 2, 4);
      t_halt(1'b0, 1'b1, 1'b0, 8, 10);
      t_stop(1'b0);
      t_stop(1'b1);
      wrap_up();
   end
endmodule // standby_mode_controller_tb_top
